// ---- cfm_monitor.sv ----
/*
  Contact feedback monitor: supervises forced-guided feedback
  contacts of external relays driven by the safety output pair.
  Assumes feedback and switch inputs are asynchronous pins, the
  safety output pair and reset request come from logic on ref_clk_i,
  and software uses an Avalon-MM master.
*/
// Chosen here: the address map and the Avalon-MM register port.
// Overview of operation
// - Reset and turn-on need all contacts closed
// - Single channel ignores feedback while outputs on
// - Single channel contacts close within 250 ms
// - Legacy single: open 200 ms, close 200 ms
// - Dual channel lockout on 250 ms disagreement
// - Legacy dual: each channel closes within 200 ms
// - Modes single, dual, none; dual default
// - Dual channel keeps per channel fault flags
// - Single mode drives aux output following outputs
// - Wiring mismatch flags error, blocks config changes
// - Differing switch banks at power-up lock out
`include "cfm_regs.svh"

module cfm_monitor #(
  parameter int TICK_CYCLES = `CFM_TICK_CYC
) (
  input  wire logic                ref_clk_i,
  input  wire logic                arst_n_i,
  input  wire logic                ce_i,
  input  wire logic [3:0]          avs_address_i,
  input  wire logic                avs_read_i,
  input  wire logic                avs_write_i,
  input  wire logic [3:0]          avs_byteenable_i,
  input  wire logic [31:0]         avs_writedata_i,
  output logic [31:0]              avs_readdata_o,
  output logic                     avs_waitrequest_o,
  output logic                     irq_o,
  input  wire cfm_pkg::cfm_bank_t  cfg_bank_a_i,
  input  wire cfm_pkg::cfm_bank_t  cfg_bank_b_i,
  input  wire logic                feedback_input_a_i,
  input  wire logic                feedback_input_b_i,
  input  wire logic [1:0]          safety_output_pair_i,
  input  wire logic                reset_req_i,
  output logic                     reset_ack_o,
  output logic                     turn_on_ok_o,
  output logic                     aux_o,
  output logic                     aux_oe_o,
  output logic                     lockout_o,
  output logic                     cfg_change_ok_o
);

  // ========================================================
  // State and decodes
  cfm_pkg::cfm_state_t q;
  cfm_pkg::cfm_state_t d;
  logic                single;
  logic                dual;
  logic                run;
  logic                on_q;
  logic                all_closed;
  logic                wr_ok;
  logic                rd_ok;
  logic                clr;
  logic                mis;
  logic                dis_to;
  logic                open_to;
  logic                open_arm_n;
  logic [11:0]         open_cnt_n;
  logic [11:0]         dis_cnt_n;
  logic [11:0]         lim_close;
  logic [1:0]          cl_to;
  logic [1:0]          cl_arm;
  logic [1:0][11:0]    cl_cnt;
  logic [3:0]          ev;

  // Mode and bus decodes
  assign single     = q.mode == cfm_pkg::CFM_SINGLE;
  assign dual       = q.mode == cfm_pkg::CFM_DUAL;
  assign run        = q.fsm == cfm_pkg::CFM_ST_RUN;
  assign on_q       = |q.pair_q;
  assign wr_ok      = q.ack & avs_write_i;
  assign rd_ok      = q.ack & avs_read_i;
  assign clr        = wr_ok & avs_byteenable_i[0]
                    & (avs_address_i[3:2] == `CFM_OFS_CTRL)
                    & avs_writedata_i[`CFM_CTRL_CLEAR];
  assign lim_close  = (single & ~q.legacy) ? `CFM_CLOSE_MS : `CFM_LEGACY_MS;

  // Contacts closed as the selected mode sees them
  assign all_closed = single ? q.fb_sync[0] : dual ? &q.fb_sync : 1'b1;

  // ========================================================
  // Per channel close window after an output turns off
  for (genvar k = 0; k < 2; k++) begin : g_ch
    logic        was_on;
    logic        is_on;
    logic        chk;
    logic        arm_n;
    logic [11:0] cnt_n;
    logic        to_n;

    // Single mode watches the pair as one on channel 0
    assign was_on = single ? on_q : q.pair_q[k];
    assign is_on  = single ? |safety_output_pair_i : safety_output_pair_i[k];
    assign chk    = run & (single ? (k == 0) : (dual & q.legacy));

    // Arm on falling output, stop on closed contact, time out
    always_comb begin
      arm_n = q.close_arm[k];
      cnt_n = q.close_cnt[k];
      to_n  = 1'b0;
      if (!chk) begin
        arm_n = 1'b0;
      end else if (was_on & ~is_on) begin
        arm_n = 1'b1;
        cnt_n = '0;
      end else if (q.close_arm[k]) begin
        if (q.fb_sync[k]) begin
          arm_n = 1'b0;
        end else if (q.tick) begin
          cnt_n = q.close_cnt[k] + 12'd1;
          to_n  = q.close_cnt[k] == lim_close;
        end
      end
    end

    assign cl_arm[k] = arm_n;
    assign cl_cnt[k] = cnt_n;
    assign cl_to[k]  = to_n;
  end

  // ========================================================
  // Legacy single mode: contacts must open after turn-on
  always_comb begin
    open_arm_n = q.open_arm;
    open_cnt_n = q.open_cnt;
    open_to    = 1'b0;
    if (!(run & single & q.legacy)) begin
      open_arm_n = 1'b0;
    end else if (~on_q & |safety_output_pair_i) begin
      open_arm_n = 1'b1;
      open_cnt_n = '0;
    end else if (q.open_arm) begin
      if (~q.fb_sync[0]) begin
        open_arm_n = 1'b0;
      end else if (q.tick) begin
        open_cnt_n = q.open_cnt + 12'd1;
        open_to    = q.open_cnt == `CFM_LEGACY_MS;
      end
    end
  end

  // ========================================================
  // Disagreement timer: two inputs in dual, aux readback in single
  assign mis = single ? (q.fb_sync[1] != q.aux) : (q.fb_sync[0] != q.fb_sync[1]);

  always_comb begin
    dis_cnt_n = q.dis_cnt;
    dis_to    = 1'b0;
    if (!(run & mis & (single | (dual & ~q.legacy)))) begin
      dis_cnt_n = '0;
    end else if (q.tick) begin
      dis_cnt_n = q.dis_cnt + 12'd1;
      dis_to    = q.dis_cnt == `CFM_DISAGREE_MS;
    end
  end

  // ========================================================
  // Next state
  always_comb begin
    d           = q;
    ev          = '0;
    d.fb_meta   = {feedback_input_b_i, feedback_input_a_i};
    d.fb_sync   = q.fb_meta;
    d.bank_meta = {cfg_bank_b_i, cfg_bank_a_i};
    d.bank_sync = q.bank_meta;
    d.pair_q    = safety_output_pair_i;
    d.aux       = single & |safety_output_pair_i;
    d.tick      = q.tick_cnt == 24'(TICK_CYCLES - 1);
    d.tick_cnt  = d.tick ? '0 : q.tick_cnt + 24'd1;
    d.close_arm = cl_arm;
    d.close_cnt = cl_cnt;
    d.open_arm  = open_arm_n;
    d.open_cnt  = open_cnt_n;
    d.dis_cnt   = dis_cnt_n;
    d.reset_ack = 1'b0;

    // Sequencing: boot check, run, lockout
    case (q.fsm)
      cfm_pkg::CFM_ST_BOOT: begin
        d.boot = q.boot + 2'd1;
        if (q.boot == `CFM_BOOT_LAST) begin
          d.mode = q.bank_sync[0].single ? cfm_pkg::CFM_SINGLE
                 : q.bank_sync[0].none ? cfm_pkg::CFM_NONE
                 : cfm_pkg::CFM_DUAL;
          if (q.bank_sync[0] != q.bank_sync[1]) begin
            d.fsm                = cfm_pkg::CFM_ST_LOCK;
            d.bank_err           = 1'b1;
            ev[`CFM_EV_BANK]     = 1'b1;
            ev[`CFM_EV_LOCK]     = 1'b1;
          end else begin
            d.fsm = cfm_pkg::CFM_ST_RUN;
          end
        end
      end
      cfm_pkg::CFM_ST_RUN: begin
        if (dis_to & single) begin
          d.wire_err       = 1'b1;
          ev[`CFM_EV_WIRE] = 1'b1;
        end
        if ((|cl_to) | open_to | (dis_to & dual)) begin
          d.fsm            = cfm_pkg::CFM_ST_LOCK;
          ev[`CFM_EV_LOCK] = 1'b1;
          d.chan_fault     = q.chan_fault | cl_to
                           | (dis_to & dual ? ~q.fb_sync : 2'b00);
        end else if (reset_req_i) begin
          d.reset_ack        = all_closed;
          ev[`CFM_EV_REFUSE] = ~all_closed;
        end
      end
      cfm_pkg::CFM_ST_LOCK: begin
        ev[`CFM_EV_REFUSE] = reset_req_i;
        if (clr & ~q.bank_err) begin
          d.fsm        = cfm_pkg::CFM_ST_RUN;
          d.chan_fault = '0;
          d.wire_err   = 1'b0;
        end
      end
      default: begin
        d.fsm = cfm_pkg::CFM_ST_BOOT;
      end
    endcase

    // Turn-on allowed with closed contacts, held while on
    d.turn_on_ok = (d.fsm == cfm_pkg::CFM_ST_RUN) & (all_closed | on_q);

    // Register writes take effect when waitrequest is low
    if (wr_ok & avs_byteenable_i[0]) begin
      case (avs_address_i[3:2])
        `CFM_OFS_CTRL: d.legacy = avs_writedata_i[`CFM_CTRL_LEGACY];
        `CFM_OFS_MASK: d.mask = avs_writedata_i[`CFM_EV_W-1:0];
        default: d.mask = q.mask;
      endcase
    end

    // Sticky events, a read clears only the bits it returned, set wins
    d.status = (q.status & ~((rd_ok & (avs_address_i[3:2] == `CFM_OFS_STATUS))
                             ? q.rdata[`CFM_EV_W-1:0] : 4'h0))
             | ev;

    // One wait cycle per request, read data latched with it
    d.ack = (avs_read_i | avs_write_i) & ~q.ack;
    if (avs_read_i & ~q.ack) begin
      case (avs_address_i[3:2])
        `CFM_OFS_CTRL:   d.rdata = {31'h0, q.legacy};
        `CFM_OFS_STATUS: d.rdata = {28'h0, q.status};
        `CFM_OFS_MASK:   d.rdata = {28'h0, q.mask};
        `CFM_OFS_STATE:  d.rdata = {22'h0, q.chan_fault, q.fb_sync, q.mode,
                                    q.wire_err, q.bank_err, q.fsm};
        default:         d.rdata = 32'h0;
      endcase
    end
  end

  // ========================================================
  // State register, frozen while the clock enable is low
  always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      q <= '0;
    end else if (ce_i) begin
      q <= d;
    end
  end

  // ========================================================
  // Outputs
  assign avs_readdata_o    = q.rdata;
  assign avs_waitrequest_o = (avs_read_i | avs_write_i) & ~q.ack;
  assign irq_o             = |(q.status & q.mask);
  assign reset_ack_o       = q.reset_ack;
  assign turn_on_ok_o      = q.turn_on_ok;
  assign aux_o             = q.aux;
  assign aux_oe_o          = single;
  assign lockout_o         = q.fsm == cfm_pkg::CFM_ST_LOCK;
  assign cfg_change_ok_o   = ~q.wire_err;

  // ========================================================
  // Checks
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (!arst_n_i);

  property p_refuse;
    ce_i && run && reset_req_i && !all_closed |=> !reset_ack_o && q.status[`CFM_EV_REFUSE];
  endproperty
  a_refuse: assert property (p_refuse) else $error("reset taken with open contacts");

  property p_onok;
    $rose(turn_on_ok_o) |-> $past(all_closed);
  endproperty
  a_onok: assert property (p_onok) else $error("turn-on allowed with open contacts");

  property p_ignore;
    ce_i && run && single && !q.legacy && on_q && |safety_output_pair_i
      && !q.close_arm[0] |=> !lockout_o;
  endproperty
  a_ignore: assert property (p_ignore) else $error("feedback not ignored while on");

  property p_close;
    ce_i && run && single && q.close_arm[0] && !q.fb_sync[0] && q.tick
      && q.close_cnt[0] == lim_close |=> lockout_o;
  endproperty
  a_close: assert property (p_close) else $error("missed close window lockout");

  property p_open;
    ce_i && run && single && q.legacy && q.open_arm && q.fb_sync[0] && q.tick
      && q.open_cnt == `CFM_LEGACY_MS |=> lockout_o;
  endproperty
  a_open: assert property (p_open) else $error("missed open window lockout");

  property p_dis;
    ce_i && run && dual && !q.legacy && mis ##1 ce_i && !mis |=> q.dis_cnt == 12'h0;
  endproperty
  a_dis: assert property (p_dis) else $error("disagree timer not restarted");

  property p_ldual;
    ce_i && run && dual && q.legacy && q.pair_q[1] && !safety_output_pair_i[1]
      |=> q.close_arm[1] && q.close_cnt[1] == 12'h0;
  endproperty
  a_ldual: assert property (p_ldual) else $error("channel close window not armed");

  property p_mode;
    ce_i && q.fsm == cfm_pkg::CFM_ST_BOOT && q.boot == `CFM_BOOT_LAST
      && q.bank_sync == '0 |=> q.mode == cfm_pkg::CFM_DUAL;
  endproperty
  a_mode: assert property (p_mode) else $error("default mode not dual");

  property p_diag;
    ce_i && run && dual && cl_to[1] |=> q.chan_fault[1] && lockout_o;
  endproperty
  a_diag: assert property (p_diag) else $error("channel fault not recorded");

  property p_aux;
    ce_i |=> aux_o == ($past(|safety_output_pair_i) && aux_oe_o);
  endproperty
  a_aux: assert property (p_aux) else $error("aux output not following outputs");

  property p_wire;
    ce_i && run && single && mis && q.tick && q.dis_cnt == `CFM_DISAGREE_MS
      |=> !cfg_change_ok_o;
  endproperty
  a_wire: assert property (p_wire) else $error("wiring mismatch not flagged");

  property p_bank;
    ce_i && q.fsm == cfm_pkg::CFM_ST_BOOT && q.boot == `CFM_BOOT_LAST
      && q.bank_sync[0] != q.bank_sync[1] |=> lockout_o ##1 lockout_o;
  endproperty
  a_bank: assert property (p_bank) else $error("switch bank mismatch not locked");

  property p_hold;
    lockout_o && !(ce_i && clr) |=> lockout_o;
  endproperty
  a_hold: assert property (p_hold) else $error("lockout left without clear");

  c_reset: cover property (reset_ack_o);
  c_lock:  cover property ($rose(lockout_o));
  c_clear: cover property ($fell(lockout_o));
  c_irq:   cover property (irq_o);

endmodule

// ---- cfm_regs.svh ----
/*
  Offsets, field positions, reset values and timing counts of the
  contact feedback monitor.
  Assumes a 100 MHz register clock and byte addresses on the bus.
*/
`ifndef CFM_REGS_SVH
`define CFM_REGS_SVH

// ==========================================================
// Timing
`define CFM_CLK_HZ      100000000
`define CFM_TICK_MS     1
`define CFM_TICK_CYC    (`CFM_CLK_HZ / 1000 * `CFM_TICK_MS)
`define CFM_CLOSE_MS    12'd250
`define CFM_LEGACY_MS   12'd200
`define CFM_DISAGREE_MS 12'd250
`define CFM_BOOT_LAST   2'd3

// ==========================================================
// Register offsets, bits [3:2] of the byte address
`define CFM_OFS_CTRL    2'h0
`define CFM_OFS_STATUS  2'h1
`define CFM_OFS_MASK    2'h2
`define CFM_OFS_STATE   2'h3

// ==========================================================
// Field positions
`define CFM_CTRL_LEGACY 0
`define CFM_CTRL_CLEAR  1
`define CFM_EV_LOCK     0
`define CFM_EV_REFUSE   1
`define CFM_EV_WIRE     2
`define CFM_EV_BANK     3
`define CFM_EV_W        4
`define CFM_MASK_RST    4'h0

`endif

// ---- cfm_pkg.sv ----
/*
  Types of the contact feedback monitor: modes, states, switch bank
  layout and the packed state record.
  Assumes cfm_regs.svh holds the numeric constants.
*/
package cfm_pkg;

  // ========================================================
  // Monitoring modes, dual first so it is the reset value
  typedef enum logic [1:0] {
    CFM_DUAL,
    CFM_SINGLE,
    CFM_NONE
  } cfm_mode_t;

  // Top level states
  typedef enum logic [1:0] {
    CFM_ST_BOOT,
    CFM_ST_RUN,
    CFM_ST_LOCK
  } cfm_fsm_t;

  // One configuration switch bank
  typedef struct packed {
    logic none;
    logic single;
  } cfm_bank_t;

  // ========================================================
  // Complete state of the monitor
  typedef struct packed {
    cfm_fsm_t              fsm;
    logic [1:0]            boot;
    cfm_mode_t             mode;
    logic                  legacy;
    logic [1:0]            fb_meta;
    logic [1:0]            fb_sync;
    cfm_bank_t [1:0]       bank_meta;
    cfm_bank_t [1:0]       bank_sync;
    logic [1:0]            pair_q;
    logic                  aux;
    logic [23:0]           tick_cnt;
    logic                  tick;
    logic [1:0]            close_arm;
    logic [1:0][11:0]      close_cnt;
    logic                  open_arm;
    logic [11:0]           open_cnt;
    logic [11:0]           dis_cnt;
    logic                  bank_err;
    logic                  wire_err;
    logic [1:0]            chan_fault;
    logic [3:0]            status;
    logic [3:0]            mask;
    logic                  ack;
    logic [31:0]           rdata;
    logic                  reset_ack;
    logic                  turn_on_ok;
  } cfm_state_t;

endpackage

// ---- cfm_contacts.sv ----
/*
  Behavioural model of two forced-guided relays whose normally
  closed monitor contacts feed the contact feedback monitor.
  Assumes the coil drive is the safety output pair on ref_clk_i.
*/
module cfm_contacts (
  input  wire logic       ref_clk_i,
  input  wire logic       arst_n_i,
  input  wire logic [1:0] coil_i,
  input  int              dly_i,
  input  wire logic [1:0] stuck_i,
  output logic [1:0]      closed_o
);
  timeunit 1ns;
  timeprecision 1ps;

  logic [1:0][11:0] cnt_q;

  // ========================================================
  // Contact motion
  // Contacts follow the coil dly_i + 1 cycles after it changes; stuck holds one open
  always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      closed_o <= 2'h3;
      cnt_q    <= '0;
    end else begin
      for (int k = 0; k < 2; k++) begin
        if (stuck_i[k]) begin
          closed_o[k] <= 1'b0;
          cnt_q[k]    <= '0;
        end else if (closed_o[k] == !coil_i[k]) begin
          cnt_q[k] <= '0;
        end else if (int'(cnt_q[k]) >= dly_i) begin
          closed_o[k] <= !coil_i[k];
          cnt_q[k]    <= '0;
        end else begin
          cnt_q[k] <= cnt_q[k] + 12'h001;
        end
      end
    end
  end
endmodule

// ---- cfm_monitor_tb.sv ----
/*
  Self-checking bench of the contact feedback monitor.
  Assumes cfm_pkg and cfm_contacts are compiled first.
*/
module cfm_monitor_tb;
  timeunit 1ns;
  timeprecision 1ps;

  logic                ref_clk = 1'b0;
  logic                arst_n  = 1'b0;
  logic [3:0]          address = 4'h0;
  logic                rd      = 1'b0;
  logic                wr      = 1'b0;
  logic [31:0]         wdata   = 32'h0;
  logic [31:0]         rdata;
  logic                waitreq, irq, ack, ok, aux, aux_oe, lock, cfg_ok;
  cfm_pkg::cfm_bank_t  bank_a  = 2'h0;
  cfm_pkg::cfm_bank_t  bank_b  = 2'h0;
  logic [1:0]          pair    = 2'h0;
  logic [1:0]          stuck   = 2'h0;
  logic [1:0]          closed;
  logic                req     = 1'b0;
  int                  dly     = 4;
  int                  n_errors = 0;
  int                  n_tests  = 0;
  logic                tie_a    = 1'b0;
  logic                jumper   = 1'b0;
  logic                short_b  = 1'b0;
  logic [31:0]         rdata_s;
  // Receiver wiring of the two feedback terminals per mode
  wire logic           fb_a = tie_a | (bank_a.single ? &closed : closed[0]);
  wire logic           fb_b = aux_oe ? (aux & !short_b)
                            : jumper ? fb_a : closed[1];

  // Clock of 100 MHz
  always #5 ref_clk = ~ref_clk;

  // ========================================================
  // Instances
  cfm_monitor #(.TICK_CYCLES(4)) i_cfm_monitor (
    .ref_clk_i            (ref_clk),
    .arst_n_i             (arst_n),
    .ce_i                 (1'b1),
    .avs_address_i        (address),
    .avs_read_i           (rd),
    .avs_write_i          (wr),
    .avs_byteenable_i     (4'hf),
    .avs_writedata_i      (wdata),
    .avs_readdata_o       (rdata),
    .avs_waitrequest_o    (waitreq),
    .irq_o                (irq),
    .cfg_bank_a_i         (bank_a),
    .cfg_bank_b_i         (bank_b),
    .feedback_input_a_i   (fb_a),
    .feedback_input_b_i   (fb_b),
    .safety_output_pair_i (pair),
    .reset_req_i          (req),
    .reset_ack_o          (ack),
    .turn_on_ok_o         (ok),
    .aux_o                (aux),
    .aux_oe_o             (aux_oe),
    .lockout_o            (lock),
    .cfg_change_ok_o      (cfg_ok)
  );

  cfm_contacts i_cfm_contacts (
    .ref_clk_i (ref_clk),
    .arst_n_i  (arst_n),
    .coil_i    (pair),
    .dly_i     (dly),
    .stuck_i   (stuck),
    .closed_o  (closed)
  );

  // ========================================================
  // Tasks
  task automatic check(input string name, input logic [31:0] exp, input logic [31:0] got);
    n_tests++;
    if (got !== exp) begin
      $display("ERROR %s expected %h seen %h", name, exp, got);
      n_errors++;
    end
  endtask

  task automatic chk1(input string name, input logic exp, input logic got);
    check(name, {31'h0, exp}, {31'h0, got});
  endtask

  // Avalon cycle held until waitrequest is sampled low
  task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d,
                     output logic [31:0] q);
    int n;
    n = 0;
    @(posedge ref_clk);
    rd      <= !w;
    wr      <= w;
    address <= a;
    wdata   <= d;
    do begin
      @(posedge ref_clk);
      n++;
    end while (waitreq !== 1'b0 && n < 50);
    q = rdata;
    rd <= 1'b0;
    wr <= 1'b0;
    if (n >= 50) check("waitrequest", 32'h0, 32'h1);
  endtask

  task automatic rdchk(input logic [3:0] a, input logic [31:0] exp, input string name);
    logic [31:0] q;
    bus(1'b0, a, 32'h0, q);
    check(name, exp, q);
  endtask

  task automatic wreg(input logic [3:0] a, input logic [31:0] d);
    logic [31:0] q;
    bus(1'b1, a, d, q);
  endtask

  task automatic try_reset(input logic exp);
    logic seen;
    seen = 1'b0;
    @(posedge ref_clk);
    req <= 1'b1;
    @(posedge ref_clk);
    req <= 1'b0;
    repeat (3) begin
      @(posedge ref_clk);
      seen |= ack;
    end
    chk1("reset_ack", exp, seen);
  endtask

  task automatic power_up(input cfm_pkg::cfm_bank_t a, input cfm_pkg::cfm_bank_t b);
    @(posedge ref_clk);
    bank_a <= a;
    bank_b <= b;
    arst_n <= 1'b0;
    repeat (12) @(posedge ref_clk);
    arst_n <= 1'b1;
    repeat (8) @(posedge ref_clk);
  endtask

  task automatic wait_cyc(input int n);
    repeat (n) @(posedge ref_clk);
  endtask

  task automatic wrap_up();
    $display("Checks %0d, errors %0d", n_tests, n_errors);
    if (n_errors == 0 && n_tests > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  // ========================================================
  // Tests
  // Main sequence
  initial begin
    power_up(2'h0, 2'h0);
    rdchk(4'hd, 32'h0000_00c1, "state_dual");
    rdchk(4'h8, 32'h0, "mask_reset");
    rdchk(4'h0, 32'h0, "ctrl_reset");
    wreg(4'h8, 32'hf);
    stuck  <= 2'h2;
    jumper <= 1'b1;
    wait_cyc(10);
    try_reset(1'b1);
    jumper <= 1'b0;
    wait_cyc(10);
    try_reset(1'b0);
    wait_cyc(1);
    chk1("irq_o", 1'b1, irq);
    rdchk(4'h4, 32'h2, "status_refused");
    wait_cyc(1);
    chk1("irq_clear", 1'b0, irq);
    stuck <= 2'h0;
    wait_cyc(10);
    try_reset(1'b1);
    pair <= 2'h3;
    wait_cyc(2);
    chk1("turn_on_ok", 1'b1, ok);
    wait_cyc(20);
    pair <= 2'h0;
    wait_cyc(20);
    stuck <= 2'h1;
    wait_cyc(900);
    chk1("lock_early", 1'b0, lock);
    wait_cyc(200);
    chk1("lock_late", 1'b1, lock);
    rdchk(4'hc, 32'h0000_0182, "state_fault");
    rdchk(4'h4, 32'h1, "status_lock");
    try_reset(1'b0);
    stuck <= 2'h0;
    wait_cyc(20);
    chk1("lock_held", 1'b1, lock);
    wreg(4'h0, 32'h2);
    wait_cyc(2);
    chk1("lock_cleared", 1'b0, lock);
    rdchk(4'h4, 32'h2, "status_lock_refused");
    wreg(4'h0, 32'h1);
    try_reset(1'b1);
    pair <= 2'h3;
    wait_cyc(20);
    pair  <= 2'h0;
    stuck <= 2'h2;
    wait_cyc(700);
    chk1("lock_legacy_early", 1'b0, lock);
    wait_cyc(200);
    chk1("lock_legacy", 1'b1, lock);
    rdchk(4'hc, 32'h0000_0242, "state_legacy");
    stuck <= 2'h0;
    power_up(2'h1, 2'h1);
    rdchk(4'hc, 32'h0000_0051, "state_single");
    chk1("aux_oe", 1'b1, aux_oe);
    chk1("cfg_ok", 1'b1, cfg_ok);
    stuck <= 2'h3;
    tie_a <= 1'b1;
    wait_cyc(10);
    try_reset(1'b1);
    stuck <= 2'h0;
    tie_a <= 1'b0;
    wait_cyc(10);
    try_reset(1'b1);
    dly     <= 800;
    pair    <= 2'h3;
    short_b <= 1'b1;
    wait_cyc(3);
    chk1("aux_on", 1'b1, aux);
    wait_cyc(1100);
    chk1("lock_ignored", 1'b0, lock);
    chk1("cfg_mismatch", 1'b0, cfg_ok);
    short_b <= 1'b0;
    pair <= 2'h0;
    wait_cyc(1100);
    chk1("lock_close_ok", 1'b0, lock);
    chk1("aux_off", 1'b0, aux);
    dly <= 1200;
    pair <= 2'h3;
    wait_cyc(1300);
    pair <= 2'h0;
    wait_cyc(900);
    chk1("lock_slow_early", 1'b0, lock);
    wait_cyc(250);
    chk1("lock_slow", 1'b1, lock);
    power_up(2'h0, 2'h1);
    chk1("lock_bank", 1'b1, lock);
    bus(1'b0, 4'h4, 32'h0, rdata_s);
    chk1("status_bank", 1'b1, rdata_s[3]);
    wreg(4'h0, 32'h2);
    wait_cyc(2);
    chk1("lock_bank_held", 1'b1, lock);
    wrap_up();
  end

  // Watchdog against a hang
  initial begin
    wait_cyc(20000);
    n_errors++;
    wrap_up();
  end
endmodule
